// ### dual_dac_input_latch.sv
// Purpose: digital front end of a dual current-output converter
// Assumes: strobes and clocks sampled on clk_sys; pins are asynchronous
// Notes: analog transfer is off-chip; outputs carry the latched codes
// Summary of operation
// - dual-port: each channel has own data, write strobe, update clock
// - input words are unsigned straight binary, top bit most significant
// - output current is code over two to resolution times full scale
// - all ones gives full scale on primary, none on complement
// - capture by edge-triggered registers, never transparent latches
// - update every rising clock edge dual, every second interleaved
// - update clocks up to 125 MSPS per channel
// - any duty cycle works if each phase meets minimum width
// - two timing modes; interleaved reassigns control inputs
// - mode input high selects dual-port, low selects interleaved
// - write strobe loads input latch, update clock loads converter latch
// - interleaved strobe writes latch one when select high, else two
// - sync reset high blocks clock; first edge after, then every second
`timescale 1ns/1ps
`include "dac_latch_consts.svh"
module dual_dac_input_latch import dac_latch_pkg::*; #(
	parameter int WIDTH = `RES_BITS
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic mode_select,
	input wire logic [WIDTH-1:0] data_port1,
	input wire logic [WIDTH-1:0] data_port2,
	input wire logic write_strobe_ch1,
	input wire logic write_strobe_ch2,
	input wire logic update_clock_ch1,
	input wire logic update_clock_ch2,
	input wire logic code_ready,
	output logic [WIDTH-1:0] code_ch1,
	output logic [WIDTH-1:0] code_ch2,
	output logic [WIDTH-1:0] comp_code_ch1,
	output logic [WIDTH-1:0] comp_code_ch2,
	output logic code_valid,
	output logic input_ready,
	output logic loaded
);
	// sample rate bound: one update per clk_sys cycle at most
	localparam int MAX_UPDATE_MHZ = `UPDATE_RATE_MHZ;

	pin_edge_if wr1 ();
	pin_edge_if wr2 ();
	pin_edge_if ck1 ();
	pin_edge_if ck2 ();
	logic [2:0] mode_sync;
	logic [WIDTH-1:0] d1_s1, d1_s2, d2_s1, d2_s2;
	logic mode_dual;
	logic next_mode_dual;

	// control pins, edges counted so any duty cycle works
	pin_sync u_wr1 (.clk_sys(clk_sys), .srst(srst),
		.pin(write_strobe_ch1), .edge_o(wr1.src));
	pin_sync u_wr2 (.clk_sys(clk_sys), .srst(srst),
		.pin(write_strobe_ch2), .edge_o(wr2.src));
	pin_sync u_ck1 (.clk_sys(clk_sys), .srst(srst),
		.pin(update_clock_ch1), .edge_o(ck1.src));
	pin_sync u_ck2 (.clk_sys(clk_sys), .srst(srst),
		.pin(update_clock_ch2), .edge_o(ck2.src));

	// data delayed two stages to line up with the strobe edge
	always_ff @(posedge clk_sys) begin
		d1_s1 <= data_port1;
		d1_s2 <= d1_s1;
		d2_s1 <= data_port2;
		d2_s2 <= d2_s1;
	end

	// mode pin synchroniser; second and third stages must agree
	always_comb begin
		next_mode_dual = mode_dual;
		if (mode_sync[2] == mode_sync[1]) begin
			next_mode_dual = (mode_sync[2] == `MODE_DUAL);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mode_sync <= 3'h7;
			mode_dual <= `MODE_DUAL;
		end else begin
			mode_sync <= {mode_sync[1:0], mode_select};
			mode_dual <= next_mode_dual;
		end
	end

	// input latches, converter latches and interleave phase
	logic [WIDTH-1:0] in1, in2, dac1, dac2;
	logic [WIDTH-1:0] next_in1, next_in2, next_dac1, next_dac2;
	logic got_wr, got_ck, next_got_wr, next_got_ck;
	phase_t phase, next_phase;
	logic upd, next_upd;

	always_comb begin
		next_in1 = in1;
		next_in2 = in2;
		next_dac1 = dac1;
		next_dac2 = dac2;
		next_phase = phase;
		next_got_wr = got_wr;
		next_got_ck = got_ck;
		next_upd = 1'h0;
		if (mode_dual) begin
			// channels fully independent
			if (wr1.rise) begin
				next_in1 = d1_s2;
				next_got_wr = 1'h1;
			end
			if (wr2.rise) begin
				next_in2 = d2_s2;
			end
			// clock edge takes the old input latch, before a same-edge write
			if (ck1.rise) begin
				next_dac1 = in1;
				next_upd = 1'h1;
				next_got_ck = 1'h1;
			end
			if (ck2.rise) begin
				next_dac2 = in2;
				next_upd = 1'h1;
			end
			next_phase = PH_ARMED;
		end else begin
			// ch1 strobe is write, ch2 strobe is select
			if (wr1.rise) begin
				next_got_wr = 1'h1;
				if (wr2.level == `SEL_CH1) begin
					next_in1 = d1_s2;
				end else begin
					next_in2 = d1_s2;
				end
			end
			// ch2 clock acts as sync reset
			if (ck2.level) begin
				next_phase = PH_ARMED;
			end else if (ck1.rise) begin
				case (phase)
					PH_ARMED: begin
						next_dac1 = in1;
						next_dac2 = in2;
						next_upd = 1'h1;
						next_got_ck = 1'h1;
						next_phase = PH_HOLD;
					end
					default: begin
						next_phase = PH_ARMED;
					end
				endcase
			end
		end
	end

	// latch data unreset: contents undefined until loaded
	always_ff @(posedge clk_sys) begin
		in1 <= next_in1;
		in2 <= next_in2;
		dac1 <= next_dac1;
		dac2 <= next_dac2;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			phase <= PH_ARMED;
			got_wr <= 1'h0;
			got_ck <= 1'h0;
			upd <= 1'h0;
		end else begin
			phase <= next_phase;
			got_wr <= next_got_wr;
			got_ck <= next_got_ck;
			upd <= next_upd;
		end
	end

	// two-entry skid buffer toward the analog side; an update arriving while both entries are full is dropped
	logic [2*WIDTH-1:0] buf0, buf1, next_buf0, next_buf1;
	logic [1:0] cnt, next_cnt;
	logic push, pop;

	always_comb begin
		push = upd && cnt != 2'h2;
		pop = code_ready && cnt != 2'h0;
		next_buf0 = buf0;
		next_buf1 = buf1;
		next_cnt = cnt;
		case ({push, pop})
			2'h2: begin
				if (cnt == 2'h0) begin
					next_buf0 = {dac2, dac1};
				end else begin
					next_buf1 = {dac2, dac1};
				end
				next_cnt = cnt + 2'h1;
			end
			2'h1: begin
				next_buf0 = buf1;
				next_cnt = cnt - 2'h1;
			end
			2'h3: begin
				if (cnt == 2'h1) begin
					next_buf0 = {dac2, dac1};
				end else begin
					next_buf0 = buf1;
					next_buf1 = {dac2, dac1};
				end
			end
			default: begin
				next_cnt = cnt;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cnt <= 2'h0;
			buf0 <= '0;
			buf1 <= '0;
		end else begin
			cnt <= next_cnt;
			buf0 <= next_buf0;
			buf1 <= next_buf1;
		end
	end

	// outputs straight from flops; complement is all-ones minus code, except srst clears both to zero
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			code_ch1 <= '0;
			code_ch2 <= '0;
			comp_code_ch1 <= '0;
			comp_code_ch2 <= '0;
			code_valid <= 1'h0;
			input_ready <= 1'h0;
			loaded <= 1'h0;
		end else begin
			code_ch1 <= next_buf0[WIDTH-1:0];
			code_ch2 <= next_buf0[2*WIDTH-1:WIDTH];
			comp_code_ch1 <= ~next_buf0[WIDTH-1:0];
			comp_code_ch2 <= ~next_buf0[2*WIDTH-1:WIDTH];
			code_valid <= next_cnt != 2'h0;
			input_ready <= next_cnt != 2'h2;
			loaded <= next_got_wr & next_got_ck;
		end
	end
endmodule // dual_dac_input_latch

// ### dac_latch_consts.svh
// Purpose: named constants for the dual converter input latch
// Assumes: included by bare name
// Notes: definitions only
`ifndef DAC_LATCH_CONSTS_SVH
`define DAC_LATCH_CONSTS_SVH
`define RES_BITS 14
`define MODE_DUAL 1'h1
`define MODE_INTERLEAVE 1'h0
`define SEL_CH1 1'h1
`define UPDATE_RATE_MHZ 125
`endif

// ### dac_latch_pkg.sv
// Purpose: shared types for the dual converter input latch
// Assumes: one-hot state codes
// Notes: types only, constants live in the header
package dac_latch_pkg;
	typedef enum logic [1:0] {
		PH_HOLD = 2'h1,
		PH_ARMED = 2'h2
	} phase_t;
endpackage

// ### pin_edge_if.sv
// Purpose: carries one synchronised pin and its rising edge
// Assumes: single clock domain
// Notes: driven by pin_sync, read by the top
`timescale 1ns/1ps
interface pin_edge_if;
	logic level;
	logic rise;
	modport src (output level, output rise);
	modport dst (input level, input rise);
endinterface

// ### pin_sync.sv
// Purpose: three-stage synchroniser with rising edge detect
// Assumes: srst synchronous active high
// Notes: stage one read only by stage two
`timescale 1ns/1ps
module pin_sync (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic pin,
	pin_edge_if.src edge_o
);
	logic [2:0] sync;
	logic [2:0] next_sync;
	logic level;
	logic next_level;

	// shift in, a change counts once stages two and three agree
	always_comb begin
		next_sync = {sync[1:0], pin};
		next_level = level;
		if (sync[2] == sync[1]) begin
			next_level = sync[2];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sync <= 3'h0;
			level <= 1'h0;
		end else begin
			sync <= next_sync;
			level <= next_level;
		end
	end

	assign edge_o.level = level;
	assign edge_o.rise = next_level & ~level;
endmodule // pin_sync

// ### dac_latch_chk_sva.sv
// Purpose: port checker for the dual input latch
// Assumes: sees the top ports only
// Notes: bind follows the module
`timescale 1ns/1ps
module dac_latch_chk #(
	parameter int WIDTH = 14
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic update_clock_ch1,
	input wire logic update_clock_ch2,
	input wire logic code_ready,
	input wire logic [WIDTH-1:0] code_ch1,
	input wire logic [WIDTH-1:0] code_ch2,
	input wire logic [WIDTH-1:0] comp_code_ch1,
	input wire logic [WIDTH-1:0] comp_code_ch2,
	input wire logic code_valid,
	input wire logic input_ready,
	input wire logic loaded
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	// full scale split between the two outputs
	a_comp_ch1: assert property (
		code_valid |-> comp_code_ch1 == ~code_ch1) else $error("comp ch1");
	a_comp_ch2: assert property (
		code_valid |-> comp_code_ch2 == ~code_ch2) else $error("comp ch2");
	// a stalled head word must not move
	a_stall_hold: assert property (
		code_valid && !code_ready |=> code_valid && $stable(code_ch1)
		&& $stable(code_ch2)) else $error("head moved");
	a_stall_comp: assert property (
		code_valid && !code_ready ##1 code_valid |-> $stable(comp_code_ch1))
		else $error("comp moved");
	// quiet clocks long enough leave nothing in flight
	a_clock_idle: assert property (
		(!update_clock_ch1 && !update_clock_ch2) [*8] |=> !$rose(code_valid))
		else $error("update without clock");
	a_loaded_keep: assert property (
		loaded |=> loaded) else $error("loaded dropped");
	// drops on a full buffer never block a pop
	a_pop_frees: assert property (
		code_valid && code_ready |=> input_ready) else $error("no room");
	a_full_cause: assert property (
		$fell(input_ready) |-> code_valid && $past(code_valid))
		else $error("full while empty");
	c_pop: cover property (code_valid && code_ready);
	c_stall: cover property (code_valid && !code_ready);
	c_full: cover property ($fell(input_ready));
endmodule // dac_latch_chk
bind dual_dac_input_latch dac_latch_chk #(.WIDTH(WIDTH)) chk (.*);

// ### dac_source.sv
// Purpose: data source model for the latch pins
// Assumes: pins move on falling clk_sys only
// Notes: data inverted once its hold has passed
`timescale 1ns/1ps
module dac_source #(
	parameter int W = 14
) (
	input wire logic clk_sys,
	output logic [W-1:0] data1,
	output logic [W-1:0] data2,
	output logic [3:0] pins
);
	initial begin
		data1 = '0;
		data2 = '0;
		pins = 4'h0;
	end
	// four cycles a phase, above the two-cycle minimum
	task automatic strobe(input logic [3:0] m);
		@(negedge clk_sys);
		pins = pins | m;
		repeat (4) @(negedge clk_sys);
		pins = pins & ~m;
		repeat (4) @(negedge clk_sys);
	endtask
	// stale data must not look valid
	task automatic send(input logic [3:0] m, input logic [W-1:0] a, b);
		@(negedge clk_sys);
		data1 = a;
		data2 = b;
		strobe(m);
		data1 = ~a;
		data2 = ~b;
	endtask
	task automatic level(input int i, input logic v);
		@(negedge clk_sys);
		pins[i] = v;
	endtask
endmodule // dac_source

// ### dual_dac_input_latch_test.sv
// Purpose: self-checking bench for the dual input latch
// Assumes: pins {ck2,ck1,wr2,wr1} from the source model
// Notes: expected pairs queued, checked at each pop
`timescale 1ns/1ps
`include "dac_latch_consts.svh"
module dual_dac_input_latch_test;
	localparam int W = `RES_BITS;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic mode_select = `MODE_DUAL;
	logic code_ready = 1'b1;
	logic [W-1:0] d1, d2, c1, c2, k1, k2, a, b;
	logic [3:0] pins;
	logic code_valid, input_ready, loaded;
	logic [2*W-1:0] exp_q[$];
	int failures = 0;
	int cmp_count = 0;
	int seed = 32'h6E4A;
	always #4 clk_sys = ~clk_sys;
	dac_source #(.W(W)) src (.clk_sys(clk_sys), .data1(d1), .data2(d2),
		.pins(pins));
	dual_dac_input_latch #(.WIDTH(W)) uut (.clk_sys(clk_sys), .srst(srst),
		.mode_select(mode_select), .data_port1(d1), .data_port2(d2),
		.write_strobe_ch1(pins[0]), .write_strobe_ch2(pins[1]),
		.update_clock_ch1(pins[2]), .update_clock_ch2(pins[3]),
		.code_ready(code_ready), .code_ch1(c1), .code_ch2(c2),
		.comp_code_ch1(k1), .comp_code_ch2(k2), .code_valid(code_valid),
		.input_ready(input_ready), .loaded(loaded));
	task automatic chk(input string n, input logic [2*W-1:0] e, g);
		cmp_count++;
		if (e !== g) begin
			failures++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic stop_test();
		if (failures == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic drain();
		for (int i = 0; i < 300 && exp_q.size() > 0; i++)
			@(negedge clk_sys);
		if (exp_q.size() > 0) begin
			failures++;
			stop_test();
		end
	endtask
	// write both ports, then clock both; keep=0 when a drop is due
	task automatic both(input logic [W-1:0] x, y, input bit keep);
		src.send(4'h3, x, y);
		if (keep)
			exp_q.push_back({y, x});
		src.strobe(4'hC);
	endtask
	// every pop must match the oldest queued pair
	always @(posedge clk_sys) begin
		if (code_valid === 1'b1 && code_ready === 1'b1) begin
			if (exp_q.size() == 0)
				chk("extra word", '0, '1);
			else begin
				chk("code", exp_q[0], {c2, c1});
				chk("comp", ~exp_q.pop_front(), {k2, k1});
			end
		end
	end
	initial begin
		repeat (20) @(negedge clk_sys);
		srst = 1'b0;
		repeat (6) @(negedge clk_sys);
		both('1, '0, 1);
		chk("loaded", 1, loaded);
		both('0, '1, 1);
		for (int i = 0; i < 6; i++) begin
			a = W'($random(seed));
			b = W'($random(seed));
			// random stall on odd passes only, so no word is ever dropped
			code_ready = a[0] | ~i[0];
			both(a, b, 1);
		end
		code_ready = 1'h1;
		// channel one alone moves, two keeps its word
		src.send(4'h1, ~b, a);
		exp_q.push_back({b, ~b});
		src.strobe(4'h4);
		// stalled receiver: two words kept, the third refused
		code_ready = 1'b0;
		for (int i = 0; i < 3; i++)
			both(a ^ W'(i), b, i < 2);
		chk("input_ready", 0, input_ready);
		code_ready = 1'b1;
		drain();
		// interleaved: sync reset high hides the clock
		mode_select = `MODE_INTERLEAVE;
		// mode sync settles first, so a ck2 rise is never an update
		repeat (6) @(negedge clk_sys);
		src.level(3, 1'b1);
		repeat (6) @(negedge clk_sys);
		src.strobe(4'h4);
		src.level(3, 1'b0);
		src.level(1, `SEL_CH1);
		src.send(4'h1, a, a);
		src.level(1, ~`SEL_CH1);
		src.send(4'h1, b, b);
		exp_q.push_back({b, a});
		src.strobe(4'h4);
		src.strobe(4'h4);
		src.level(1, `SEL_CH1);
		src.send(4'h1, ~a, ~a);
		exp_q.push_back({b, ~a});
		src.strobe(4'h4);
		drain();
		stop_test();
	end
endmodule // dual_dac_input_latch_test
